/* rtl/ecpc_counter.sv */
// Summary of operation
// - x1: A rise up, A fall down
// - x2: every A edge steps count
// - x4: every A or B edge steps
// - index high in phase loads reload value
// - reload phase selectable among four states
// - count step applied before reload
// - reload within one timebase period
// - two-pulse: A rise up, B rise down
// - no counting before software arms
// - sample clock captures count, never clears
// - sample clock edge selectable rise/fall
// - each sample handed to dma stream
// - first start edge begins count, later ignored
// - gate edge stops, latches save register
// - start and gate edges chosen independently
// - single mode waits for save read
// - buffered restarts on gate, streams result
// - pulse: delay edges then width edges high
// - timebase active edge selectable
// - triggered pulse: delay counted from gate
// - triggered pulse honours first trigger only
// - count register is 32 bits
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps

// ==========================================================
// synchroniser: two flops, plus a third stage for edge detection
module ecpc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] cur,
	output logic      [W-1:0] prv
);
	logic [W-1:0] meta_r;

	// only the second stage reads meta_r
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			cur    <= '0;
			prv    <= '0;
		end else begin
			meta_r <= din;
			cur    <= meta_r;
			prv    <= cur;
		end
	end
endmodule

`timescale 1ns/1ps

// ==========================================================
// top: encoder, edge-separation and pulse counter with apb slave
module ecpc_counter #(
	parameter int CW = ecpc_pkg::CNT_W
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          enc_a,
	input  wire logic          enc_b,
	input  wire logic          enc_z,
	input  wire logic          gate_in,
	input  wire logic          aux_in,
	input  wire logic          sclk_in,
	input  wire logic          tb_in,
	output logic               pulse_out,
	output logic               dma_valid,
	output logic      [CW-1:0] dma_data,
	input  wire logic          dma_ready
);

	// ==========================================================
	// input conditioning
	logic [ecpc_pkg::IN_N-1:0] in_cur;
	logic [ecpc_pkg::IN_N-1:0] in_prv;
	logic [ecpc_pkg::IN_N-1:0] in_rise;
	logic [ecpc_pkg::IN_N-1:0] in_fall;

	ecpc_sync #(.W(ecpc_pkg::IN_N)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({tb_in, sclk_in, aux_in, gate_in, enc_z, enc_b, enc_a}),
		.cur     (in_cur),
		.prv     (in_prv)
	);

	assign in_rise = in_cur & ~in_prv;
	assign in_fall = ~in_cur & in_prv;

	// ==========================================================
	// registers
	ecpc_pkg::ecpc_ctrl_t  ctrl_r;
	logic [CW-1:0]         reload_r;
	logic [CW-1:0]         delay_r;
	logic [CW-1:0]         width_r;
	logic [CW-1:0]         cnt_r;
	logic [CW-1:0]         cnt_nxt;
	logic [CW-1:0]         save_r;
	ecpc_pkg::ecpc_state_t state_r;
	ecpc_pkg::ecpc_state_t state_nxt;
	ecpc_pkg::ecpc_beat_t  beat_r;
	logic                  done_r;
	logic                  ovr_r;
	logic                  pulse_r;

	logic apb_acc;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic arm_go;
	logic save_rd;

	// access phase taken once; pready rises one cycle after penable
	assign apb_acc = psel & penable & ~pready;
	// a write lands only at the edge that also shows pready to the master
	assign wr_en   = psel & penable & pready & pwrite;
	assign rd_en   = apb_acc & ~pwrite;
	assign hit     = (paddr == ecpc_pkg::OFF_CTRL)   | (paddr == ecpc_pkg::OFF_RELOAD) |
	                 (paddr == ecpc_pkg::OFF_DELAY)  | (paddr == ecpc_pkg::OFF_WIDTH)  |
	                 (paddr == ecpc_pkg::OFF_COUNT)  | (paddr == ecpc_pkg::OFF_SAVE)   |
	                 (paddr == ecpc_pkg::OFF_STATUS);
	assign arm_go  = wr_en & (paddr == ecpc_pkg::OFF_CTRL) & pwdata[0] & ~ctrl_r.arm;
	assign save_rd = rd_en & (paddr == ecpc_pkg::OFF_SAVE);

	// ==========================================================
	// event decode
	logic mode_pos;
	logic armed;
	logic a_edge;
	logic b_edge;
	logic dir_a;
	logic dir_b;
	logic step_up;
	logic step_dn;
	logic rld_hit;
	logic tb_act;
	logic gate_act;
	logic aux_act;
	logic samp_act;

	assign armed    = ctrl_r.arm;
	assign mode_pos = (ctrl_r.mode == ecpc_pkg::MD_X1) | (ctrl_r.mode == ecpc_pkg::MD_X2) |
	                  (ctrl_r.mode == ecpc_pkg::MD_X4) | (ctrl_r.mode == ecpc_pkg::MD_TWOP);
	assign a_edge   = in_cur[ecpc_pkg::IN_A] ^ in_prv[ecpc_pkg::IN_A];
	assign b_edge   = in_cur[ecpc_pkg::IN_B] ^ in_prv[ecpc_pkg::IN_B];
	// a leading b: an A edge ends with A != B, a B edge ends with A == B
	assign dir_a    = in_cur[ecpc_pkg::IN_A] ^ in_cur[ecpc_pkg::IN_B];
	assign dir_b    = ~(in_cur[ecpc_pkg::IN_A] ^ in_cur[ecpc_pkg::IN_B]);
	assign tb_act   = ctrl_r.tb_fall ? in_fall[ecpc_pkg::IN_TB] : in_rise[ecpc_pkg::IN_TB];
	assign gate_act = ctrl_r.gate_fall ? in_fall[ecpc_pkg::IN_GATE]
	                                   : in_rise[ecpc_pkg::IN_GATE];
	assign aux_act  = ctrl_r.aux_fall ? in_fall[ecpc_pkg::IN_AUX] : in_rise[ecpc_pkg::IN_AUX];
	assign samp_act = ctrl_r.sclk_fall ? in_fall[ecpc_pkg::IN_SCLK]
	                                   : in_rise[ecpc_pkg::IN_SCLK];

	// quadrature and two-pulse step decode
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		case (ctrl_r.mode)
			ecpc_pkg::MD_X1: begin
				step_up = in_rise[ecpc_pkg::IN_A] & dir_a;
				step_dn = in_fall[ecpc_pkg::IN_A] & ~dir_a;
			end
			ecpc_pkg::MD_X2: begin
				step_up = a_edge & dir_a;
				step_dn = a_edge & ~dir_a;
			end
			ecpc_pkg::MD_X4: begin
				step_up = (a_edge & dir_a) | (b_edge & ~a_edge & dir_b);
				step_dn = (a_edge & ~dir_a) | (b_edge & ~a_edge & ~dir_b);
			end
			ecpc_pkg::MD_TWOP: begin
				// simultaneous rises on both channels cancel out
				step_up = in_rise[ecpc_pkg::IN_A] & ~in_rise[ecpc_pkg::IN_B];
				step_dn = in_rise[ecpc_pkg::IN_B] & ~in_rise[ecpc_pkg::IN_A];
			end
			default: begin
				step_up = 1'b0;
				step_dn = 1'b0;
			end
		endcase
	end

	// index reload: phase decoded from the synchronised A/B pair
	assign rld_hit = ctrl_r.rl_en & (ctrl_r.mode != ecpc_pkg::MD_TWOP) & mode_pos &
	                 ({in_cur[ecpc_pkg::IN_A], in_cur[ecpc_pkg::IN_B]} == ctrl_r.rl_phase) &
	                 in_cur[ecpc_pkg::IN_Z];

	// ==========================================================
	// counter and sequencer next state
	always_comb begin
		cnt_nxt   = cnt_r;
		state_nxt = state_r;
		if (arm_go) begin
			cnt_nxt = '0;
			case (pwdata[3:1])
				ecpc_pkg::MD_SEP1,
				ecpc_pkg::MD_SEPB,
				ecpc_pkg::MD_TRIG:  state_nxt = ecpc_pkg::ST_WAIT;
				ecpc_pkg::MD_PULSE: state_nxt = ecpc_pkg::ST_RUN;
				default:            state_nxt = ecpc_pkg::ST_IDLE;
			endcase
		end else if (!armed) begin
			state_nxt = ecpc_pkg::ST_IDLE;
		end else if (mode_pos) begin
			if (step_up)
				cnt_nxt = cnt_r + 1'b1;
			else if (step_dn)
				cnt_nxt = cnt_r - 1'b1;
			// reload overrides after the step; same cycle as the phase is seen
			if (rld_hit)
				cnt_nxt = reload_r;
		end else begin
			case (state_r)
				ecpc_pkg::ST_WAIT: begin
					if ((ctrl_r.mode == ecpc_pkg::MD_TRIG) && gate_act) begin
						cnt_nxt   = '0;
						state_nxt = ecpc_pkg::ST_RUN;
					end else if ((ctrl_r.mode != ecpc_pkg::MD_TRIG) && aux_act) begin
						cnt_nxt   = '0;
						state_nxt = ecpc_pkg::ST_RUN;
					end
				end
				ecpc_pkg::ST_RUN: begin
					if (ctrl_r.mode == ecpc_pkg::MD_SEP1 || ctrl_r.mode == ecpc_pkg::MD_SEPB) begin
						// later start edges fall through unused here
						if (gate_act)
							state_nxt = (ctrl_r.mode == ecpc_pkg::MD_SEP1) ? ecpc_pkg::ST_DONE
							                                                : ecpc_pkg::ST_GAP;
						else if (tb_act)
							cnt_nxt = cnt_r + 1'b1;
					end else if (cnt_r == delay_r) begin
						cnt_nxt   = '0;
						state_nxt = ecpc_pkg::ST_HIGH;
					end else if (tb_act) begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
				ecpc_pkg::ST_HIGH: begin
					if (cnt_r == width_r)
						state_nxt = ecpc_pkg::ST_DONE;
					else if (tb_act)
						cnt_nxt = cnt_r + 1'b1;
				end
				ecpc_pkg::ST_GAP: begin
					cnt_nxt = '0;
					if (gate_act)
						state_nxt = ecpc_pkg::ST_RUN;
				end
				ecpc_pkg::ST_DONE: begin
					// single separation rearms only after software has the result
					if (save_rd && ctrl_r.mode == ecpc_pkg::MD_SEP1)
						state_nxt = ecpc_pkg::ST_WAIT;
				end
				default: state_nxt = ecpc_pkg::ST_IDLE;
			endcase
		end
	end

	// count and sequencer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r   <= ecpc_pkg::RST_WORD;
			state_r <= ecpc_pkg::ST_IDLE;
		end else begin
			cnt_r   <= cnt_nxt;
			state_r <= state_nxt;
		end
	end

	// save register latches the measured interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			save_r <= ecpc_pkg::RST_WORD;
		else if (armed && !arm_go && state_r == ecpc_pkg::ST_RUN && gate_act &&
		         (ctrl_r.mode == ecpc_pkg::MD_SEP1 || ctrl_r.mode == ecpc_pkg::MD_SEPB))
			save_r <= cnt_r;
	end

	// pulse output follows the high state, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pulse_r <= 1'b0;
		else
			pulse_r <= (state_nxt == ecpc_pkg::ST_HIGH);
	end

	// ==========================================================
	// dma stream: one word register; a new capture overwrites and flags overrun
	logic cap_samp;
	logic cap_sep;

	assign cap_samp = armed & !arm_go & mode_pos & ctrl_r.sample_en & samp_act;
	assign cap_sep  = armed & !arm_go & (ctrl_r.mode == ecpc_pkg::MD_SEPB) &
	                  (state_r == ecpc_pkg::ST_RUN) & gate_act;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			beat_r <= '0;
		end else if (cap_samp) begin
			beat_r.valid <= 1'b1;
			beat_r.data  <= cnt_nxt;
		end else if (cap_sep) begin
			beat_r.valid <= 1'b1;
			beat_r.data  <= cnt_r;
		end else if (dma_ready) begin
			beat_r.valid <= 1'b0;
		end
	end

	// sticky flags: hardware set beats a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
			ovr_r  <= 1'b0;
		end else begin
			if (state_nxt == ecpc_pkg::ST_DONE && state_r != ecpc_pkg::ST_DONE)
				done_r <= 1'b1;
			else if (wr_en && paddr == ecpc_pkg::OFF_STATUS && pwdata[0])
				done_r <= 1'b0;
			if ((cap_samp || cap_sep) && beat_r.valid && !dma_ready)
				ovr_r <= 1'b1;
			else if (wr_en && paddr == ecpc_pkg::OFF_STATUS && pwdata[1])
				ovr_r <= 1'b0;
		end
	end

	// ==========================================================
	// apb slave: writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= ecpc_pkg::RST_WORD;
			reload_r <= ecpc_pkg::RST_WORD;
			delay_r  <= ecpc_pkg::RST_DELAY;
			width_r  <= ecpc_pkg::RST_WIDTH;
		end else if (wr_en) begin
			case (paddr)
				ecpc_pkg::OFF_CTRL:   ctrl_r   <= {20'h00000, pwdata[11:0]};
				ecpc_pkg::OFF_RELOAD: reload_r <= pwdata;
				ecpc_pkg::OFF_DELAY:  delay_r  <= pwdata;
				ecpc_pkg::OFF_WIDTH:  width_r  <= pwdata;
				default:              ;
			endcase
		end
	end

	// read data, ready and error are all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= ecpc_pkg::RST_WORD;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_acc;
			pslverr <= apb_acc & ~hit;
			prdata  <= ecpc_pkg::RST_WORD;
			if (rd_en) begin
				case (paddr)
					ecpc_pkg::OFF_CTRL:   prdata <= ctrl_r;
					ecpc_pkg::OFF_RELOAD: prdata <= reload_r;
					ecpc_pkg::OFF_DELAY:  prdata <= delay_r;
					ecpc_pkg::OFF_WIDTH:  prdata <= width_r;
					ecpc_pkg::OFF_COUNT:  prdata <= cnt_r;
					ecpc_pkg::OFF_SAVE:   prdata <= save_r;
					ecpc_pkg::OFF_STATUS: prdata <= {18'h00000, state_r, 4'h0, pulse_r,
					                                 beat_r.valid, ovr_r, done_r};
					default:              prdata <= ecpc_pkg::RST_WORD;
				endcase
			end
		end
	end

	assign pulse_out = pulse_r;
	assign dma_valid = beat_r.valid;
	assign dma_data  = beat_r.data;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_pos_live;
		armed && !arm_go && mode_pos && !rld_hit;
	endsequence

	sequence s_trig_seen;
		armed && !arm_go && ctrl_r.mode == ecpc_pkg::MD_TRIG && state_r == ecpc_pkg::ST_WAIT
		&& gate_act;
	endsequence

	AST_X1_UP: assert property (
		s_pos_live and (ctrl_r.mode == ecpc_pkg::MD_X1 && in_rise[0] && !in_cur[1])
		|=> cnt_r == $past(cnt_r) + 32'h0000_0001)
		else $error("x1 rising A with A leading did not add one");

	AST_X2_DOWN: assert property (
		s_pos_live and (ctrl_r.mode == ecpc_pkg::MD_X2 && a_edge && !dir_a)
		|=> cnt_r == $past(cnt_r) - 32'h0000_0001)
		else $error("x2 A edge with B leading did not subtract one");

	AST_X4_B_EDGE: assert property (
		s_pos_live and (ctrl_r.mode == ecpc_pkg::MD_X4 && b_edge && !a_edge)
		|=> cnt_r != $past(cnt_r))
		else $error("x4 B edge did not step the count");

	AST_RELOAD: assert property (
		armed && !arm_go && rld_hit |=> cnt_r == $past(reload_r))
		else $error("index in reload phase did not load reload value");

	AST_TWOP_B: assert property (
		s_pos_live and (ctrl_r.mode == ecpc_pkg::MD_TWOP && in_rise[1] && !in_rise[0])
		|=> cnt_r == $past(cnt_r) - 32'h0000_0001)
		else $error("two-pulse B rise did not subtract one");

	AST_UNARMED: assert property (
		!armed && !arm_go |=> $stable(cnt_r))
		else $error("count moved while disarmed");

	AST_SAMPLE: assert property (
		cap_samp |=> dma_valid && dma_data == cnt_r)
		else $error("sample edge did not capture the running count");

	AST_SEP_LATCH: assert property (
		armed && !arm_go && state_r == ecpc_pkg::ST_RUN && gate_act &&
		ctrl_r.mode == ecpc_pkg::MD_SEP1 |=> save_r == $past(cnt_r) && state_r == ecpc_pkg::ST_DONE)
		else $error("gate edge did not latch the interval");

	AST_SEP_HOLD: assert property (
		armed && state_r == ecpc_pkg::ST_DONE && ctrl_r.mode == ecpc_pkg::MD_SEP1 && !save_rd
		&& !arm_go |=> state_r == ecpc_pkg::ST_DONE && $stable(save_r))
		else $error("single separation left done before the save read");

	AST_TRIG_START: assert property (
		s_trig_seen |=> state_r == ecpc_pkg::ST_RUN ##1 state_r != ecpc_pkg::ST_WAIT)
		else $error("trigger did not start the delay");

	AST_PULSE_HIGH: assert property (
		state_r == ecpc_pkg::ST_RUN && armed && !arm_go && !mode_pos &&
		(ctrl_r.mode == ecpc_pkg::MD_PULSE || ctrl_r.mode == ecpc_pkg::MD_TRIG) &&
		cnt_r == delay_r |=> pulse_out)
		else $error("pulse did not rise once the delay elapsed");

endmodule

/* rtl/ecpc_pkg.sv */
package ecpc_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_DELAY  = 8'h08;
	localparam logic [7:0] OFF_WIDTH  = 8'h0C;
	localparam logic [7:0] OFF_COUNT  = 8'h10;
	localparam logic [7:0] OFF_SAVE   = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// ==========================================================
	// widths and reset values
	localparam int          CNT_W      = 32;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [31:0] RST_DELAY  = 32'h0000_0001;
	localparam logic [31:0] RST_WIDTH  = 32'h0000_0001;

	// ==========================================================
	// input bit positions inside the synchroniser vector
	localparam int IN_A    = 0;
	localparam int IN_B    = 1;
	localparam int IN_Z    = 2;
	localparam int IN_GATE = 3;
	localparam int IN_AUX  = 4;
	localparam int IN_SCLK = 5;
	localparam int IN_TB   = 6;
	localparam int IN_N    = 7;

	// ==========================================================
	// operating modes (ctrl.mode)
	typedef enum logic [2:0] {
		MD_X1    = 3'h0,
		MD_X2    = 3'h1,
		MD_X4    = 3'h2,
		MD_TWOP  = 3'h3,
		MD_SEP1  = 3'h4,
		MD_SEPB  = 3'h5,
		MD_PULSE = 3'h6,
		MD_TRIG  = 3'h7
	} ecpc_mode_t;

	// sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_WAIT = 6'h02,
		ST_RUN  = 6'h04,
		ST_HIGH = 6'h08,
		ST_GAP  = 6'h10,
		ST_DONE = 6'h20
	} ecpc_state_t;

	// control word, bit 31 downward to arm at bit 0
	typedef struct packed {
		logic [19:0] rsvd;
		logic        sclk_fall;
		logic        gate_fall;
		logic        aux_fall;
		logic        tb_fall;
		logic [1:0]  rl_phase;
		logic        rl_en;
		logic        sample_en;
		ecpc_mode_t  mode;
		logic        arm;
	} ecpc_ctrl_t;

	// stream word toward the dma engine
	typedef struct packed {
		logic             valid;
		logic [CNT_W-1:0] data;
	} ecpc_beat_t;

endpackage

/* tb/ecpc_src.sv */
`timescale 1ns/1ps

// ==========================================================
// encoder, trigger and timebase source
module ecpc_src (
	input  wire logic pclk,
	output logic      enc_a,
	output logic      enc_b,
	output logic      enc_z,
	output logic      gate_in,
	output logic      aux_in,
	output logic      sclk_in,
	output logic      tb_in
);
	// levels idle low until the bench moves them
	initial begin
		enc_a   = 1'b0;
		enc_b   = 1'b0;
		enc_z   = 1'b0;
		gate_in = 1'b0;
		aux_in  = 1'b0;
		sclk_in = 1'b0;
		tb_in   = 1'b0;
	end

	// set one line, then hold it; 6 clocks is above the 2-clock minimum
	task put(input int idx, input logic val);
		case (idx)
			ecpc_pkg::IN_A:    enc_a   <= val;
			ecpc_pkg::IN_B:    enc_b   <= val;
			ecpc_pkg::IN_Z:    enc_z   <= val; // only raised inside the chosen phase
			ecpc_pkg::IN_GATE: gate_in <= val;
			ecpc_pkg::IN_AUX:  aux_in  <= val;
			ecpc_pkg::IN_SCLK: sclk_in <= val;
			default:           tb_in   <= val;
		endcase
		repeat (6) @(posedge pclk);
	endtask

	// one high pulse on a line
	task pls(input int idx);
		put(idx, 1'b1);
		put(idx, 1'b0);
	endtask

	// one full quadrature cycle, A leading when fwd is set
	task quad(input logic fwd);
		int p;
		int q;
		p = fwd ? ecpc_pkg::IN_A : ecpc_pkg::IN_B;
		q = fwd ? ecpc_pkg::IN_B : ecpc_pkg::IN_A;
		put(p, 1'b1);
		put(q, 1'b1);
		put(p, 1'b0);
		put(q, 1'b0);
	endtask
endmodule

/* tb/ecpc_counter_tb.sv */
`timescale 1ns/1ps

// ==========================================================
// bench top
module ecpc_counter_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        enc_a;
	logic        enc_b;
	logic        enc_z;
	logic        gate_in;
	logic        aux_in;
	logic        sclk_in;
	logic        tb_in;
	logic        pulse_out;
	logic        dma_valid;
	logic [31:0] dma_data;
	logic        dma_ready;
	logic [31:0] r;
	logic        e;
	int          err_total;
	int          compares;
	int          cyc;
	int          m;

	ecpc_counter ecpc_counter_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
		.enc_z(enc_z), .gate_in(gate_in), .aux_in(aux_in), .sclk_in(sclk_in),
		.tb_in(tb_in), .pulse_out(pulse_out), .dma_valid(dma_valid),
		.dma_data(dma_data), .dma_ready(dma_ready)
	);

	ecpc_src ecpc_src_i (
		.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
		.gate_in(gate_in), .aux_in(aux_in), .sclk_in(sclk_in), .tb_in(tb_in)
	);

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
	end
	always #5 pclk = ~pclk;

	// hang guard, well above the roughly one thousand clocks the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			test_done();
		end
	end

	// ==========================================================
	// checking and closing
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done();
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// apb master: setup, access, wait for pready; only the hang guard ends a wait
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// disarm, then arm with a new control word so count restarts at zero
	task arm(input logic [31:0] c);
		wr(ecpc_pkg::OFF_CTRL, 32'h0000_0000);
		wr(ecpc_pkg::OFF_CTRL, c | 32'h0000_0001);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		dma_ready = 1'b0;
		err_total = 0;
		compares = 0;
		cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(ecpc_pkg::OFF_CTRL);  chk(r, 32'h0000_0000);
		rd(ecpc_pkg::OFF_DELAY); chk(r, 32'h0000_0001);
		rd(ecpc_pkg::OFF_WIDTH); chk(r, 32'h0000_0001);
		rd(8'h1C); chk({31'h0, e}, 32'h0000_0001);
		// encoder edges before arming must leave the count alone
		ecpc_src_i.quad(1'b1);
		rd(ecpc_pkg::OFF_COUNT); chk(r, 32'h0000_0000);
		// x1, x2, x4: two cycles up, one down nets 1, 2, 4 steps
		for (m = 0; m < 3; m++) begin
			arm(32'(m) << 1);
			ecpc_src_i.quad(1'b1);
			ecpc_src_i.quad(1'b1);
			ecpc_src_i.quad(1'b0);
			rd(ecpc_pkg::OFF_COUNT); chk(r, 32'h1 << m);
		end
		// index reload in phase A low B low, then normal x4 counting
		wr(ecpc_pkg::OFF_RELOAD, 32'h0000_0055);
		arm(32'h0000_0024);
		ecpc_src_i.pls(ecpc_pkg::IN_Z);
		ecpc_src_i.quad(1'b1);
		rd(ecpc_pkg::OFF_COUNT); chk(r, 32'h0000_0059);
		// two-pulse: wrap below zero shows the full 32-bit width
		arm(32'h0000_0006);
		ecpc_src_i.pls(ecpc_pkg::IN_B);
		rd(ecpc_pkg::OFF_COUNT); chk(r, 32'hFFFF_FFFF);
		repeat (3) ecpc_src_i.pls(ecpc_pkg::IN_A);
		rd(ecpc_pkg::OFF_COUNT); chk(r, 32'h0000_0002);
		// sampled position on rising, then falling sample edge
		arm(32'h0000_0010);
		ecpc_src_i.quad(1'b1);
		ecpc_src_i.quad(1'b1);
		ecpc_src_i.pls(ecpc_pkg::IN_SCLK);
		chk({31'h0, dma_valid}, 32'h0000_0001);
		chk(dma_data, 32'h0000_0002);
		dma_ready <= dma_valid;
		repeat (2) @(posedge pclk);
		dma_ready <= 1'b0;
		@(posedge pclk);
		chk({31'h0, dma_valid}, 32'h0000_0000);
		wr(ecpc_pkg::OFF_CTRL, 32'h0000_0811);
		ecpc_src_i.quad(1'b1);
		ecpc_src_i.put(ecpc_pkg::IN_SCLK, 1'b1);
		chk({31'h0, dma_valid}, 32'h0000_0000);
		ecpc_src_i.put(ecpc_pkg::IN_SCLK, 1'b0);
		chk(dma_data, 32'h0000_0003);
		// buffered separation: untaken word gets overwritten and flags overrun
		arm(32'h0000_000A);
		ecpc_src_i.pls(ecpc_pkg::IN_AUX);
		repeat (2) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		chk(dma_data, 32'h0000_0002);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		ecpc_src_i.pls(ecpc_pkg::IN_TB);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		chk(dma_data, 32'h0000_0001);
		rd(ecpc_pkg::OFF_STATUS); chk(r, 32'h0000_1006);
		wr(ecpc_pkg::OFF_STATUS, 32'h0000_0002);
		rd(ecpc_pkg::OFF_STATUS); chk(r, 32'h0000_1004);
		// single edge separation: stray edges before and after are ignored
		arm(32'h0000_0008);
		repeat (2) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		ecpc_src_i.pls(ecpc_pkg::IN_AUX);
		repeat (3) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		ecpc_src_i.pls(ecpc_pkg::IN_AUX);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		repeat (2) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		rd(ecpc_pkg::OFF_SAVE); chk(r, 32'h0000_0003);
		// single pulse: delay 2, width 3 timebase edges
		wr(ecpc_pkg::OFF_DELAY, 32'h0000_0002);
		wr(ecpc_pkg::OFF_WIDTH, 32'h0000_0003);
		arm(32'h0000_000C);
		ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0000);
		ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0001);
		repeat (2) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0001);
		ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0000);
		// triggered pulse on falling timebase edges; a second trigger is ignored
		arm(32'h0000_010E);
		repeat (3) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0000);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		repeat (2) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0001);
		repeat (3) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		ecpc_src_i.pls(ecpc_pkg::IN_GATE);
		repeat (2) ecpc_src_i.pls(ecpc_pkg::IN_TB);
		chk({31'h0, pulse_out}, 32'h0000_0000);
		test_done();
	end
endmodule
